// ### core/ucg_pkg.sv
// constants, register map and rule summary for the unit clock gating bank
// Summary of operation
// RULE1 - rate field code 1 gives 250K samples/s, code 0 gives 125K samples/s
// RULE2 - a rate above the part maximum is never configured; it is clamped
// RULE3 - watchdog gate bit 3 set clocks the watchdog; clear stops and disables it
// RULE4 - every gate bit is the clock enable of one unit; clear saves power
// RULE5 - any access to an unclocked unit ends with a bus fault
// RULE6 - gate bits reset to zero so every unit starts unclocked
// RULE7 - run, sleep and deep-sleep copies apply in their own power state
// RULE8 - sleep and deep-sleep copies apply only when auto gating select is set
// RULE9 - deep-sleep register at 0x120: pwm bit 20, converter bit 16, watchdog bit 3
// RULE10 - software keeps reserved bits unchanged in read-modify-write
// RULE11 - with auto gating select clear the run copy also governs sleep states
package ucg_pkg;
   localparam logic [11:0] UCG_RUN_OFS    = 12'h100;
   localparam logic [11:0] UCG_SLEEP_OFS  = 12'h110;
   localparam logic [11:0] UCG_DEEP_OFS   = 12'h120;
   localparam logic [11:0] UCG_CFG_OFS    = 12'h060;
   localparam logic [11:0] UCG_STAT_OFS   = 12'h050;
   localparam logic [11:0] UCG_MASK_OFS   = 12'h054;
   localparam logic [11:0] UCG_STATE_OFS  = 12'h058;
   localparam int          UCG_BIT_WDT    = 3;
   localparam int          UCG_BIT_ADC    = 16;
   localparam int          UCG_BIT_PWM    = 20;
   localparam int          UCG_RATE_LO    = 8;
   localparam int          UCG_BIT_ACG    = 0;
   localparam logic [31:0] UCG_GATE_WMASK = 32'h0011_0308;
   localparam logic [31:0] UCG_DEEP_WMASK = 32'h0011_0008;
   localparam logic [31:0] UCG_RUN_RST    = 32'h0000_0000;
   localparam logic [31:0] UCG_DEEP_RST   = 32'h0000_0040;
   localparam logic [1:0]  UCG_RATE_125K  = 2'h0;
   localparam logic [1:0]  UCG_RATE_250K  = 2'h1;
   localparam logic [1:0]  UCG_RATE_MAX   = 2'h1;
   localparam int          UCG_NUNIT      = 3;
   localparam int          UCG_NEV        = 2;
   typedef enum logic [1:0] {UCG_PS_RUN, UCG_PS_SLEEP, UCG_PS_DEEP} ucg_pstate_t;
endpackage

// ### core/ucg_gate_if.sv
// gated unit enables and converter rate between top and selector
`timescale 1ns/10ps
interface ucg_gate_if;
   import ucg_pkg::*;
   logic [UCG_NUNIT-1:0] en;
   logic [1:0]           rate;
   modport src (output en, output rate);
   modport dst (input en, input rate);
endinterface

// ### core/ucg_sel.sv
// power state selection of the active gating copy
`timescale 1ns/10ps
module ucg_sel
   import ucg_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   input  wire logic [31:0] i_run,
   input  wire logic [31:0] i_sleep,
   input  wire logic [31:0] i_deep,
   input  wire logic        i_acg,
   input  wire ucg_pstate_t i_ps,
   ucg_gate_if.src          gate
);
   logic [31:0] act;

   always_comb begin
      act = i_run;
      if (i_acg) begin // RULE8
         case (i_ps)
            UCG_PS_SLEEP: act = i_sleep; // RULE7
            UCG_PS_DEEP:  act = i_deep;  // RULE7
            default:      act = i_run;   // RULE7
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         gate.en   <= '0; // RULE6
         gate.rate <= UCG_RATE_125K;
      end else begin
         gate.en   <= {act[UCG_BIT_PWM], act[UCG_BIT_ADC], act[UCG_BIT_WDT]}; // RULE4
         gate.rate <= act[UCG_RATE_LO+:2]; // RULE1
      end
   end

   property p_sel_off;
      @(posedge i_clk) disable iff (i_rst)
      !i_acg |=> gate.en == {$past(i_run[UCG_BIT_PWM]), $past(i_run[UCG_BIT_ADC]),
                             $past(i_run[UCG_BIT_WDT])};
   endproperty
   a_sel_off: assert property (p_sel_off) else $error("run copy not applied with auto gating off"); // RULE11
endmodule

// ### core/ucg_top.sv
// unit clock gating bank: registers, power state, gated unit enables, fault
`timescale 1ns/10ps
module ucg_top
   import ucg_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   input  wire logic [11:0] i_addr,
   input  wire logic [31:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic [31:0]      o_rdata,
   input  wire logic        i_sleep_req,
   input  wire logic        i_deep_req,
   input  wire logic [2:0]  i_unit_acc,
   output logic             o_wdt_clk_en,
   output logic             o_adc_clk_en,
   output logic             o_pwm_clk_en,
   output logic [1:0]       o_adc_rate,
   output logic             o_bus_fault,
   output logic             o_irq
);
   logic [31:0]          run_unit_gate_reg0;
   logic [31:0]          sleep_unit_gate_reg0;
   logic [31:0]          deep_sleep_unit_gate_reg0;
   logic                 auto_gating_select;
   logic [UCG_NEV-1:0]   irq_stat;
   logic [UCG_NEV-1:0]   irq_mask;
   logic [UCG_NEV-1:0]   ev;
   logic [2:0]           acc_s1;
   logic [2:0]           acc_s2;
   logic                 slp_s1;
   logic                 slp_s2;
   logic                 dsl_s1;
   logic                 dsl_s2;
   logic                 rate_clamped;
   ucg_pstate_t          pstate;
   ucg_pstate_t          next_pstate;
   ucg_gate_if           gate ();

   function automatic logic [31:0] gate_wr(input logic [31:0] d, input logic [31:0] m);
      logic [31:0] r;
      r = d & m;
      if (d[UCG_RATE_LO+:2] > UCG_RATE_MAX) begin
         r[UCG_RATE_LO+:2] = UCG_RATE_MAX; // RULE2
      end
      return r;
   endfunction

   function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
      return a == o;
   endfunction

   // pins from the power controller and unit decoders are asynchronous
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         acc_s1 <= '0;
         acc_s2 <= '0;
         slp_s1 <= 1'b0;
         slp_s2 <= 1'b0;
         dsl_s1 <= 1'b0;
         dsl_s2 <= 1'b0;
      end else begin
         acc_s1 <= i_unit_acc;
         acc_s2 <= acc_s1;
         slp_s1 <= i_sleep_req;
         slp_s2 <= slp_s1;
         dsl_s1 <= i_deep_req;
         dsl_s2 <= dsl_s1;
      end
   end

   always_comb begin
      if (dsl_s2) begin
         next_pstate = UCG_PS_DEEP;
      end else if (slp_s2) begin
         next_pstate = UCG_PS_SLEEP;
      end else begin
         next_pstate = UCG_PS_RUN;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         pstate <= UCG_PS_RUN;
      end else begin
         pstate <= next_pstate;
      end
   end

   // gating copies; writes never store reserved bits, but the deep-sleep copy resets with bit 6 set
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         run_unit_gate_reg0        <= UCG_RUN_RST; // RULE6
         sleep_unit_gate_reg0      <= UCG_RUN_RST; // RULE6
         deep_sleep_unit_gate_reg0 <= UCG_DEEP_RST;
         auto_gating_select        <= 1'b0;
      end else if (i_wr) begin
         if (hit(i_addr, UCG_RUN_OFS)) begin
            run_unit_gate_reg0 <= gate_wr(i_wdata, UCG_GATE_WMASK);
         end
         if (hit(i_addr, UCG_SLEEP_OFS)) begin
            sleep_unit_gate_reg0 <= gate_wr(i_wdata, UCG_GATE_WMASK);
         end
         if (hit(i_addr, UCG_DEEP_OFS)) begin
            deep_sleep_unit_gate_reg0 <= i_wdata & UCG_DEEP_WMASK; // RULE9
         end
         if (hit(i_addr, UCG_CFG_OFS)) begin
            auto_gating_select <= i_wdata[UCG_BIT_ACG];
         end
      end
   end

   ucg_sel u_sel (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_run   (run_unit_gate_reg0),
      .i_sleep (sleep_unit_gate_reg0),
      .i_deep  (deep_sleep_unit_gate_reg0),
      .i_acg   (auto_gating_select),
      .i_ps    (pstate),
      .gate    (gate.src)
   );

   assign o_wdt_clk_en = gate.en[0]; // RULE3
   assign o_adc_clk_en = gate.en[1]; // RULE4
   assign o_pwm_clk_en = gate.en[2]; // RULE4
   assign o_adc_rate   = gate.rate;  // RULE1

   // fault on access to any unit whose clock is off
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_bus_fault <= 1'b0;
      end else begin
         o_bus_fault <= |(acc_s2 & ~gate.en); // RULE5
      end
   end

   // events: bus fault, and a clamped rate write
   assign rate_clamped = i_wr && (hit(i_addr, UCG_RUN_OFS) || hit(i_addr, UCG_SLEEP_OFS))
                         && (i_wdata[UCG_RATE_LO+:2] > UCG_RATE_MAX);
   assign ev = {rate_clamped, o_bus_fault};

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         irq_stat <= '0;
         irq_mask <= '0;
      end else begin
         if (i_wr && hit(i_addr, UCG_MASK_OFS)) begin
            irq_mask <= i_wdata[UCG_NEV-1:0];
         end
         // set wins over a write-one clear in the same cycle
         if (i_wr && hit(i_addr, UCG_STAT_OFS)) begin
            irq_stat <= (irq_stat & ~i_wdata[UCG_NEV-1:0]) | ev;
         end else begin
            irq_stat <= irq_stat | ev;
         end
      end
   end

   assign o_irq = |(irq_stat & irq_mask);

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_rdata <= '0;
      end else if (i_rd) begin
         case (i_addr)
            UCG_RUN_OFS:   o_rdata <= run_unit_gate_reg0;
            UCG_SLEEP_OFS: o_rdata <= sleep_unit_gate_reg0;
            UCG_DEEP_OFS:  o_rdata <= deep_sleep_unit_gate_reg0;
            UCG_CFG_OFS:   o_rdata <= {31'h0000_0000, auto_gating_select};
            UCG_STAT_OFS:  o_rdata <= {30'h0000_0000, irq_stat};
            UCG_MASK_OFS:  o_rdata <= {30'h0000_0000, irq_mask};
            UCG_STATE_OFS: o_rdata <= {27'h000_0000, gate.en, pstate};
            default:       o_rdata <= '0;
         endcase
      end else begin
         o_rdata <= '0;
      end
   end

   sequence s_wdt_on;
      i_wr && hit(i_addr, UCG_RUN_OFS) && i_wdata[UCG_BIT_WDT] && !auto_gating_select;
   endsequence

   property p_wdt_gate;
      @(posedge i_clk) disable iff (i_rst)
      s_wdt_on ##1 !i_wr |=> o_wdt_clk_en;
   endproperty
   a_wdt_gate: assert property (p_wdt_gate) else $error("watchdog clock not enabled"); // RULE3

   property p_unit_off;
      @(posedge i_clk) disable iff (i_rst)
      // enables follow the selected copy one edge later
      !auto_gating_select && !run_unit_gate_reg0[UCG_BIT_ADC] |=> !o_adc_clk_en;
   endproperty
   a_unit_off: assert property (p_unit_off) else $error("converter clock ran ungated"); // RULE4

   property p_fault;
      @(posedge i_clk) disable iff (i_rst)
      (acc_s2[0] && !o_wdt_clk_en) |=> o_bus_fault;
   endproperty
   a_fault: assert property (p_fault) else $error("no fault on unclocked access"); // RULE5

   property p_nofault;
      @(posedge i_clk) disable iff (i_rst)
      (acc_s2 & ~gate.en) == 3'h0 |=> !o_bus_fault;
   endproperty
   a_nofault: assert property (p_nofault) else $error("spurious fault"); // RULE5

   property p_reset;
      @(posedge i_clk) i_rst |=> run_unit_gate_reg0 == 32'h0000_0000 && gate.en == 3'h0;
   endproperty
   a_reset: assert property (p_reset) else $error("gates not cleared by reset"); // RULE6

   property p_rate_max;
      @(posedge i_clk) disable iff (i_rst) o_adc_rate <= UCG_RATE_MAX;
   endproperty
   a_rate_max: assert property (p_rate_max) else $error("rate above maximum"); // RULE2

   property p_rate;
      @(posedge i_clk) disable iff (i_rst)
      !auto_gating_select |=> o_adc_rate == $past(run_unit_gate_reg0[UCG_RATE_LO+:2]);
   endproperty
   a_rate: assert property (p_rate) else $error("rate field not applied"); // RULE1

   property p_deep;
      @(posedge i_clk) disable iff (i_rst)
      auto_gating_select && pstate == UCG_PS_DEEP && !i_wr |=>
         o_pwm_clk_en == $past(deep_sleep_unit_gate_reg0[UCG_BIT_PWM]);
   endproperty
   a_deep: assert property (p_deep) else $error("deep copy not applied"); // RULE7

   property p_deep_rsv;
      @(posedge i_clk) disable iff (i_rst)
      i_wr && hit(i_addr, UCG_DEEP_OFS) |=> (deep_sleep_unit_gate_reg0 & ~UCG_DEEP_WMASK) == 0;
   endproperty
   a_deep_rsv: assert property (p_deep_rsv) else $error("reserved deep bit stored"); // RULE9
endmodule

// ### sim/tb_top.sv
// self-checking bench for the unit clock gating bank
`timescale 1ns/10ps
module tb_top;
   import ucg_pkg::*;
   logic        i_clk       = 1'b0;
   logic        i_rst       = 1'b1;
   logic [11:0] i_addr      = 12'h000;
   logic [31:0] i_wdata     = 32'h0000_0000;
   logic        i_wr        = 1'b0;
   logic        i_rd        = 1'b0;
   logic        i_sleep_req = 1'b0;
   logic        i_deep_req  = 1'b0;
   logic [2:0]  i_unit_acc  = 3'h0;
   logic [31:0] o_rdata;
   logic        o_wdt_clk_en;
   logic        o_adc_clk_en;
   logic        o_pwm_clk_en;
   logic [1:0]  o_adc_rate;
   logic        o_bus_fault;
   logic        o_irq;
   int          bad_count   = 0;
   int          n_compared  = 0;
   logic [11:0] ofs [3]     = '{UCG_RUN_OFS, UCG_SLEEP_OFS, UCG_DEEP_OFS};
   logic [31:0] full [3]    = '{32'h0011_0108, 32'h0011_0108, 32'h0011_0008};

   ucg_top i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_sleep_req(i_sleep_req),
      .i_deep_req(i_deep_req), .i_unit_acc(i_unit_acc), .o_wdt_clk_en(o_wdt_clk_en),
      .o_adc_clk_en(o_adc_clk_en), .o_pwm_clk_en(o_pwm_clk_en), .o_adc_rate(o_adc_rate),
      .o_bus_fault(o_bus_fault), .o_irq(o_irq));

   initial begin
      forever #2.5 i_clk = ~i_clk;
   end

   task automatic results;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // enables packed as {pwm, converter, watchdog}
   task automatic chk_en(input logic [2:0] exp);
      chk({29'h0, o_pwm_clk_en, o_adc_clk_en, o_wdt_clk_en}, {29'h0, exp});
   endtask

   task automatic chk_pin(input logic got, input logic exp);
      chk({31'h0, got}, {31'h0, exp});
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_addr  <= a;
      i_wdata <= d;
      i_wr    <= 1'b1;
      @(posedge i_clk);
      i_wr    <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      @(posedge i_clk);
      i_addr <= a;
      i_rd   <= 1'b1;
      @(posedge i_clk);
      i_rd   <= 1'b0;
      #1;
      chk(o_rdata, exp);
   endtask

   task automatic done(input string name);
      $display("test %s finished, mismatches so far %0d", name, bad_count);
   endtask

   // hang guard far beyond the run time of the test
   initial begin
      #400000;
      bad_count++;
      results();
   end

   initial begin
      repeat (4) @(posedge i_clk);
      i_rst <= 1'b0;
      tick(1);
      chk_en(3'h0);
      rd(UCG_RUN_OFS, UCG_RUN_RST);
      rd(UCG_SLEEP_OFS, 32'h0000_0000);
      rd(UCG_DEEP_OFS, UCG_DEEP_RST);
      rd(12'h7FC, 32'h0000_0000);
      done("reset");
      // reserved bits drop, rate code 3 is clamped to 1
      for (int k = 0; k < 3; k++) begin
         wr(ofs[k], 32'hFFFF_FFFF);
         rd(ofs[k], full[k]);
      end
      chk_pin(o_irq, 1'b0);
      rd(UCG_STAT_OFS, 32'h0000_0002);
      wr(UCG_STAT_OFS, 32'h0000_0002);
      rd(UCG_STAT_OFS, 32'h0000_0000);
      done("reserved");
      for (int c = 0; c < 4; c++) begin
         logic [1:0] r;
         r = (c > 1) ? UCG_RATE_MAX : c[1:0];
         wr(UCG_RUN_OFS, {22'h0, c[1:0], 8'h08});
         rd(UCG_RUN_OFS, {22'h0, r, 8'h08});
         chk({30'h0, o_adc_rate}, {30'h0, r});
         chk_en(3'h1);
      end
      rd(UCG_STAT_OFS, 32'h0000_0002);
      wr(UCG_STAT_OFS, 32'h0000_0002);
      wr(UCG_RUN_OFS, 32'h0000_0000);
      tick(2);
      chk_en(3'h0);
      done("rate");
      // one distinct unit per copy shows which copy governs
      wr(UCG_RUN_OFS, 32'h0001_0000);
      wr(UCG_SLEEP_OFS, 32'h0000_0008);
      wr(UCG_DEEP_OFS, 32'h0010_0000);
      rd(UCG_DEEP_OFS, 32'h0010_0000);
      wr(UCG_DEEP_OFS, 32'h0010_0000);
      chk_en(3'h2);
      i_sleep_req <= 1'b1;
      tick(6);
      chk_en(3'h2);
      wr(UCG_CFG_OFS, 32'h0000_0001);
      tick(3);
      chk_en(3'h1);
      i_deep_req <= 1'b1;
      tick(6);
      chk_en(3'h4);
      i_deep_req  <= 1'b0;
      i_sleep_req <= 1'b0;
      tick(6);
      chk_en(3'h2);
      done("power");
      // converter clocked: no fault; watchdog unclocked: fault and irq
      wr(UCG_MASK_OFS, 32'h0000_0001);
      i_unit_acc <= 3'h2;
      tick(6);
      chk_pin(o_bus_fault, 1'b0);
      i_unit_acc <= 3'h1;
      tick(4);
      chk_pin(o_bus_fault, 1'b1);
      tick(1);
      chk_pin(o_irq, 1'b1);
      rd(UCG_STAT_OFS, 32'h0000_0001);
      i_unit_acc <= 3'h0;
      tick(4);
      chk_pin(o_bus_fault, 1'b0);
      wr(UCG_STAT_OFS, 32'h0000_0001);
      tick(1);
      chk_pin(o_irq, 1'b0);
      rd(UCG_STAT_OFS, 32'h0000_0000);
      done("fault");
      results();
   end
endmodule
